// >>> core/fesc_host.sv
// Contract
// [RULE1] Overlay mode persists after clearing; host expects it
// [RULE2] Clearing returns to standby or erase-suspend
// [RULE3] Operation failure keeps busy until cleared
// [RULE4] Failure polling: fail=1, erase=1, abort=0
// [RULE5] Failure inverse bit complements last data
// [RULE6] Failure status: valid, erase or program bit
// [RULE7] Host clears failure by reset or clear
// [RULE8] Failure accepts status read, reset, clear only
// [RULE9] Protection error busy 20-100us, status invalid
// [RULE10] Protection polling: fail=0, erase=1, abort=0
// [RULE11] Protection busy accepts only status read
// [RULE12] After protection busy: valid and protect bits
// [RULE13] After protection period any command accepted
// [RULE14] Buffer abort keeps busy until cleared
// [RULE15] Abort polling: abort=1, fail=0
// [RULE16] Abort erase bit defined only if suspended
// [RULE17] Abort status: valid, program, abort bits
// [RULE18] Host clears abort by abort reset or clear
// [RULE19] Abort accepts status read, abort reset, clear
// [RULE20] Host monitors status and issues clearing command
// [RULE21] Host masks reserved bits, ignores suspend bit
// [RULE22] Busy may last 2us after reset
// [RULE23] Commands outside accepted set are ignored
module fesc_host
  import fesc_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [11:0] flashAddr,
  output logic [15:0] flashDqOut,
  output logic flashDqOe,
  input wire logic [15:0] flashDqIn,
  output logic flashCeN,
  output logic flashOeN,
  output logic flashWeN,
  input wire logic readyBusyN
);
  import fesc_pkg::*;

  typedef enum logic [3:0] {
    S_IDLE, S_POLL1, S_POLL2, S_SRCMD, S_SRRD,
    S_UNL1, S_UNL2, S_CLRCMD, S_WAITRDY
  } fesc_state_e;

  typedef struct packed {
    fesc_state_e fsm;
    fesc_op_e op;
    logic busy;
    logic resultRdy;
    fesc_cls_e cls;
    logic [15:0] poll1;
    logic [15:0] poll2;
    logic [7:0] statWord;
    logic cycStart;
    logic cycWrite;
    logic [11:0] cycAddr;
    logic [15:0] cycData;
    logic [15:0] waitCnt;
    logic awHeld;
    logic [7:0] awAddr;
    logic wHeld;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rdyMeta;
    logic rdySync;
  } fesc_s;

  fesc_s st_ff, nxt_st;
  logic cycDone;
  logic [15:0] cycRdata;
  logic wrFire;
  logic [15:0] tgl;

  fesc_bus_cycle u_cycle (
    .mclk(mclk),
    .reset(reset),
    .start(st_ff.cycStart),
    .isWrite(st_ff.cycWrite),
    .addr(st_ff.cycAddr),
    .wdata(st_ff.cycData),
    .done(cycDone),
    .rdata(cycRdata),
    .flashAddr(flashAddr),
    .flashDqOut(flashDqOut),
    .flashDqOe(flashDqOe),
    .flashCeN(flashCeN),
    .flashOeN(flashOeN),
    .flashWeN(flashWeN),
    .flashDqIn(flashDqIn)
  );

  assign tgl = st_ff.poll1 ^ cycRdata;
  assign wrFire = st_ff.awHeld & st_ff.wHeld & ~st_ff.bvalid;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.cycStart = 1'b0;
    nxt_st.rdyMeta = readyBusyN;
    nxt_st.rdySync = st_ff.rdyMeta;
    // ----------------------------------------
    // AXI4-Lite slave
    // ----------------------------------------
    if (s_axi_awvalid && !st_ff.awHeld) begin
      nxt_st.awHeld = 1'b1;
      nxt_st.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_ff.wHeld) begin
      nxt_st.wHeld = 1'b1;
      nxt_st.wData = s_axi_wdata;
      nxt_st.wStrb = s_axi_wstrb;
    end
    if (st_ff.bvalid && s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
    end
    if (wrFire) begin
      nxt_st.awHeld = 1'b0;
      nxt_st.wHeld = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = 2'b00;
      if (st_ff.awAddr == CTRL_OFF) begin
        if (st_ff.wStrb[0] && st_ff.wData[CTRL_GO_BIT] && !st_ff.busy) begin
          nxt_st.busy = 1'b1;
          nxt_st.resultRdy = 1'b0;
          nxt_st.op = fesc_op_e'(st_ff.wData[CTRL_CMD_LSB +: CTRL_CMD_W]);
          nxt_st.fsm = S_POLL1;
          nxt_st.cycStart = 1'b1;
          nxt_st.cycWrite = 1'b0;
          nxt_st.cycAddr = 12'h000;
        end
      end else begin
        nxt_st.bresp = 2'b10;
      end
    end
    if (st_ff.rvalid && s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !st_ff.rvalid) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp = 2'b00;
      case (s_axi_araddr)
        CTRL_OFF: nxt_st.rdata = {26'h0000000, 2'(st_ff.op), 4'h0};
        STAT_OFF: nxt_st.rdata = {25'h0000000, st_ff.cls, 1'b0, st_ff.rdySync,
                                  st_ff.resultRdy, st_ff.busy};
        POLL_OFF: nxt_st.rdata = {st_ff.poll2, st_ff.poll1};
        SWRD_OFF: nxt_st.rdata = {24'h000000, st_ff.statWord};
        default: begin
          nxt_st.rdata = 32'h00000000;
          nxt_st.rresp = 2'b10;
        end
      endcase
    end
    // ----------------------------------------
    // Error detection and clearing sequencer
    // ----------------------------------------
    case (st_ff.fsm)
      S_IDLE: begin
      end
      S_POLL1: begin
        if (cycDone) begin
          nxt_st.poll1 = cycRdata;
          nxt_st.fsm = S_POLL2;
          nxt_st.cycStart = 1'b1;
        end
      end
      // [RULE20] Two reads detect toggling
      S_POLL2: begin
        if (cycDone) begin
          nxt_st.poll2 = cycRdata;
          nxt_st.fsm = S_IDLE;
          nxt_st.busy = 1'b0;
          nxt_st.resultRdy = 1'b1;
          // [RULE21] Reserved bits masked
          if (!tgl[POLL_TGL_BIT]) begin
            nxt_st.cls = FESC_CL_NONE;
          // [RULE4] Failure flag seen
          end else if (cycRdata[POLL_TLF_BIT]) begin
            nxt_st.cls = FESC_CL_OPFAIL;
          // [RULE15] Abort flag seen
          end else if (cycRdata[POLL_ABT_BIT]) begin
            nxt_st.cls = FESC_CL_ABORT;
          // [RULE10] Protection or normal busy
          end else begin
            nxt_st.cls = FESC_CL_BUSY;
          end
          if (st_ff.op != FESC_OP_POLL) begin
            nxt_st.busy = 1'b1;
            nxt_st.resultRdy = 1'b0;
            nxt_st.fsm = S_UNL1;
            nxt_st.cycStart = 1'b1;
            nxt_st.cycWrite = 1'b1;
            nxt_st.cycAddr = ADDR_UNLOCK1;
            nxt_st.cycData = CMD_UNLOCK1;
            // [RULE11] Status read issued in any class, busy included
            if (st_ff.op == FESC_OP_SRREAD) begin
              nxt_st.fsm = S_SRCMD;
              nxt_st.cycAddr = ADDR_UNLOCK1;
              nxt_st.cycData = CMD_SR_READ;
            end
          end
        end
      end
      S_SRCMD: begin
        if (cycDone) begin
          nxt_st.fsm = S_SRRD;
          nxt_st.cycStart = 1'b1;
          nxt_st.cycWrite = 1'b0;
          nxt_st.cycAddr = 12'h000;
        end
      end
      // [RULE6] Status word captured
      S_SRRD: begin
        if (cycDone) begin
          nxt_st.statWord = cycRdata[7:0];
          nxt_st.fsm = S_IDLE;
          nxt_st.busy = 1'b0;
          nxt_st.resultRdy = 1'b1;
          // [RULE12] Protect flag with valid status
          if (cycRdata[SR_VALID_BIT] && cycRdata[SR_PROT_BIT]) begin
            nxt_st.cls = FESC_CL_PROT;
          end
          // [RULE9] Invalid status means still busy
          if (!cycRdata[SR_VALID_BIT]) begin
            nxt_st.cls = FESC_CL_BUSY;
          end
        end
      end
      S_UNL1: begin
        if (cycDone) begin
          nxt_st.fsm = S_UNL2;
          nxt_st.cycStart = 1'b1;
          nxt_st.cycAddr = ADDR_UNLOCK2;
          nxt_st.cycData = CMD_UNLOCK2;
        end
      end
      // [RULE7] Reset or clear ends failure
      // [RULE18] Abort reset or clear ends abort
      S_UNL2: begin
        if (cycDone) begin
          nxt_st.fsm = S_CLRCMD;
          nxt_st.cycStart = 1'b1;
          nxt_st.cycAddr = ADDR_UNLOCK1;
          nxt_st.cycData = (st_ff.op == FESC_OP_ABORTRST) ? CMD_ABORT_RESET : CMD_SR_CLEAR;
        end
      end
      // [RULE22] Allow busy after clearing
      S_CLRCMD: begin
        if (cycDone) begin
          nxt_st.fsm = S_WAITRDY;
          nxt_st.waitCnt = 16'(RESET_BUSY_CYC + PROT_BUSY_CYC);
        end
      end
      // [RULE2] Wait for ready, or for waitCnt to run out, before reporting
      S_WAITRDY: begin
        if (st_ff.rdySync || st_ff.waitCnt == 16'h0000) begin
          nxt_st.fsm = S_IDLE;
          nxt_st.busy = 1'b0;
          nxt_st.resultRdy = 1'b1;
          nxt_st.cls = st_ff.rdySync ? FESC_CL_NONE : FESC_CL_BUSY;
        end else begin
          nxt_st.waitCnt = st_ff.waitCnt - 16'h0001;
        end
      end
      default: nxt_st.fsm = S_IDLE;
    endcase
    if (reset) begin
      nxt_st = '0;
    end
  end

  always_ff @(posedge mclk) begin
    st_ff <= nxt_st;
  end

  assign s_axi_awready = ~st_ff.awHeld;
  assign s_axi_wready = ~st_ff.wHeld;
  assign s_axi_bvalid = st_ff.bvalid;
  assign s_axi_bresp = st_ff.bresp;
  assign s_axi_arready = ~st_ff.rvalid;
  assign s_axi_rvalid = st_ff.rvalid;
  assign s_axi_rdata = st_ff.rdata;
  assign s_axi_rresp = st_ff.rresp;
endmodule : fesc_host

// >>> core/fesc_pkg.sv
package fesc_pkg;
  // Own register map (byte offsets, AXI4-Lite)
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] STAT_OFF = 8'h04;
  localparam logic [7:0] POLL_OFF = 8'h08;
  localparam logic [7:0] SWRD_OFF = 8'h0C;
  // Control fields
  localparam int CTRL_GO_BIT = 0;
  localparam int CTRL_CMD_LSB = 4;
  localparam int CTRL_CMD_W = 2;
  // Status fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_RDY_BIT = 1;
  localparam int STAT_CLS_LSB = 4;
  // Command codes written on the flash data bus, and unlock addresses
  localparam logic [15:0] CMD_RESET = 16'h00F0;
  localparam logic [15:0] CMD_SR_CLEAR = 16'h0071;
  localparam logic [15:0] CMD_SR_READ = 16'h0070;
  localparam logic [15:0] CMD_ABORT_RESET = 16'h00F0;
  localparam logic [15:0] CMD_UNLOCK1 = 16'h00AA;
  localparam logic [15:0] CMD_UNLOCK2 = 16'h0055;
  localparam logic [11:0] ADDR_UNLOCK1 = 12'h555;
  localparam logic [11:0] ADDR_UNLOCK2 = 12'h2AA;
  // Polling and status bit positions
  localparam int POLL_INV_BIT = 7;
  localparam int POLL_TGL_BIT = 6;
  localparam int POLL_TLF_BIT = 5;
  localparam int POLL_ERA_BIT = 3;
  localparam int POLL_SEC_BIT = 2;
  localparam int POLL_ABT_BIT = 1;
  localparam int SR_VALID_BIT = 7;
  localparam int SR_ERASE_BIT = 5;
  localparam int SR_PROG_BIT = 4;
  localparam int SR_ABORT_BIT = 3;
  localparam int SR_PROT_BIT = 1;
  // Timing at 10 MHz
  localparam int CLK_MHZ = 10;
  localparam int BUS_PHASE_NS = 200;
  localparam int BUS_PHASE_CYC = (BUS_PHASE_NS * CLK_MHZ + 999) / 1000;
  localparam int RESET_BUSY_US = 2;
  localparam int RESET_BUSY_CYC = RESET_BUSY_US * CLK_MHZ;
  localparam int PROT_BUSY_MAX_US = 100;
  localparam int PROT_BUSY_CYC = PROT_BUSY_MAX_US * CLK_MHZ;
  // Commands of the control register
  typedef enum logic [1:0] {
    FESC_OP_POLL,
    FESC_OP_SRREAD,
    FESC_OP_CLEAR,
    FESC_OP_ABORTRST
  } fesc_op_e;
  // Error class decided from status
  typedef enum logic [2:0] {
    FESC_CL_NONE,
    FESC_CL_OPFAIL,
    FESC_CL_PROT,
    FESC_CL_ABORT,
    FESC_CL_BUSY
  } fesc_cls_e;
endpackage : fesc_pkg

// >>> core/fesc_bus_cycle.sv
module fesc_bus_cycle
  import fesc_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic start,
  input wire logic isWrite,
  input wire logic [11:0] addr,
  input wire logic [15:0] wdata,
  output logic done,
  output logic [15:0] rdata,
  output logic [11:0] flashAddr,
  output logic [15:0] flashDqOut,
  output logic flashDqOe,
  output logic flashCeN,
  output logic flashOeN,
  output logic flashWeN,
  input wire logic [15:0] flashDqIn
);
  typedef struct packed {
    logic active;
    logic wr;
    logic [7:0] cnt;
    logic doneP;
    logic [15:0] rd;
    logic [11:0] a;
    logic [15:0] d;
  } fescb_s;
  fescb_s st_ff, nxt_st;
  logic [15:0] dqMeta_ff, dqSync_ff;

  // ----------------------------------------
  // Data pins pass two flops
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    dqMeta_ff <= flashDqIn;
    dqSync_ff <= dqMeta_ff;
  end

  always_comb begin
    nxt_st = st_ff;
    nxt_st.doneP = 1'b0;
    if (!st_ff.active) begin
      if (start) begin
        nxt_st.active = 1'b1;
        nxt_st.wr = isWrite;
        nxt_st.a = addr;
        nxt_st.d = wdata;
        nxt_st.cnt = 8'(BUS_PHASE_CYC + 2);
      end
    end else if (st_ff.cnt != 8'h00) begin
      nxt_st.cnt = st_ff.cnt - 8'h01;
    end else begin
      nxt_st.active = 1'b0;
      nxt_st.doneP = 1'b1;
      nxt_st.rd = dqSync_ff;
    end
    if (reset) begin
      nxt_st = '0;
    end
  end

  always_ff @(posedge mclk) begin
    st_ff <= nxt_st;
  end

  assign done = st_ff.doneP;
  assign rdata = st_ff.rd;
  assign flashAddr = st_ff.a;
  assign flashDqOut = st_ff.d;
  assign flashDqOe = st_ff.active & st_ff.wr;
  assign flashCeN = ~st_ff.active;
  assign flashOeN = ~(st_ff.active & ~st_ff.wr);
  // Write strobe released two cycles before end for hold
  assign flashWeN = ~(st_ff.active & st_ff.wr & (st_ff.cnt > 8'h01));
endmodule : fesc_bus_cycle

// >>> tb/fesc_flash_model.sv
module fesc_flash_model
  import fesc_pkg::*;
(
  input wire logic [11:0] flashAddr,
  input wire logic [15:0] flashDqOut,
  input wire logic flashDqOe,
  output logic [15:0] flashDqIn,
  input wire logic flashCeN,
  input wire logic flashOeN,
  input wire logic flashWeN,
  output logic readyBusyN
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] err = 2'h0;
  logic [7:0] sr = 8'h80;
  logic srNext = 1'b0;
  logic tog = 1'b0;
  logic protOn = 1'b0;
  logic [15:0] rdv;
  logic [15:0] lastOut = 16'h0000;
  initial readyBusyN = 1'b1;
  always_comb begin
    case (err)
      2'h1: rdv = {8'h00, 1'b0, tog, 1'b1, 1'b0, 1'b1, tog, 2'b00};
      2'h2: rdv = {8'h00, 1'b0, tog, 1'b0, 1'b0, 1'b1, tog, 2'b00};
      2'h3: rdv = {8'h00, 1'b1, tog, 6'b000010};
      default: rdv = 16'h5A5A;
    endcase
    if (srNext) rdv = {8'h00, sr};
  end
  // Released bus shows inverse of last word
  assign flashDqIn = flashDqOe ? flashDqOut : (!flashCeN && !flashOeN) ? rdv : ~lastOut;
  always @(posedge flashOeN) begin
    lastOut = rdv;
    tog = ~tog;
    srNext = 1'b0;
  end
  always @(posedge flashWeN) begin
    if (!flashCeN && flashDqOut == CMD_SR_READ) srNext = 1'b1;
    else if (!flashCeN && (err == 2'h1 || err == 2'h3)
             && (flashDqOut == CMD_RESET || flashDqOut == CMD_SR_CLEAR)) begin
      err = 2'h0;
      sr = 8'h80;
      readyBusyN <= #1000 1'b1;
    end
  end
  task inject(input logic [1:0] k);
    err = k;
    readyBusyN = 1'b0;
    protOn = (k == 2'h2);
    sr = (k == 2'h1) ? 8'hA0 : (k == 2'h3) ? 8'h98 : 8'h00;
  endtask : inject
  always @(posedge protOn) begin
    #50000;
    err = 2'h0;
    sr = 8'hA2;
    readyBusyN = 1'b1;
    protOn = 1'b0;
  end
endmodule : fesc_flash_model

// >>> tb/fesc_host_sva.sv
module fesc_host_sva
  import fesc_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [1:0] s_axi_rresp,
  input wire logic [11:0] flashAddr,
  input wire logic [15:0] flashDqOut,
  input wire logic flashDqOe,
  input wire logic flashCeN,
  input wire logic flashOeN,
  input wire logic flashWeN
);
  default clocking dcb @(posedge mclk); endclocking
  default disable iff (reset);
  sequence s_weLow; !flashWeN [*3] ##1 flashWeN; endsequence
  sequence s_ceLow; !flashCeN [*5]; endsequence
  property p_bHold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  a_bHold: assert property (p_bHold) else $error("write answer dropped early");
  property p_rHold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid; endproperty
  a_rHold: assert property (p_rHold) else $error("read answer dropped early");
  property p_slvErr;
    s_axi_arvalid && s_axi_arready && s_axi_araddr > SWRD_OFF |=> s_axi_rvalid
      && s_axi_rresp == 2'b10;
  endproperty
  a_slvErr: assert property (p_slvErr) else $error("unmapped read not refused");
  property p_noRdWr; flashOeN || flashWeN; endproperty
  a_noRdWr: assert property (p_noRdWr) else $error("read and write strobes together");
  property p_oeRead; flashDqOe |-> flashOeN; endproperty
  a_oeRead: assert property (p_oeRead) else $error("bus driven during read");
  property p_weInCe; !flashWeN |-> !flashCeN; endproperty
  a_weInCe: assert property (p_weInCe) else $error("write strobe outside select");
  property p_weWidth; $fell(flashWeN) |-> s_weLow; endproperty
  a_weWidth: assert property (p_weWidth) else $error("write strobe width wrong");
  property p_ceWidth; $fell(flashCeN) |-> s_ceLow; endproperty
  a_ceWidth: assert property (p_ceWidth) else $error("select too short");
  property p_wrStable;
    !flashWeN && !$past(flashWeN) |-> $stable(flashDqOut) && $stable(flashAddr);
  endproperty
  a_wrStable: assert property (p_wrStable) else $error("command moved in write");
endmodule : fesc_host_sva
bind fesc_host fesc_host_sva u_sva (.*);

// >>> tb/fesc_host_tb_top.sv
module fesc_host_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import fesc_pkg::*;
  logic mclk;
  logic reset;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [11:0] flashAddr;
  logic [15:0] flashDqOut, flashDqIn;
  logic flashDqOe, flashCeN, flashOeN, flashWeN, readyBusyN;
  int failCount = 0;
  int checksDone = 0;
  int cycles = 0;
  fesc_host dut (.*);
  fesc_flash_model flash (.*);
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // ----
  // Bus tasks
  // ----
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp) begin
      failCount++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic axiWr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axiWr
  task automatic axiRd(input logic [7:0] a);
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axiRd
  task automatic runOp(input logic [1:0] op);
    axiWr(CTRL_OFF, (32'(op) << CTRL_CMD_LSB) | 32'h1);
    do axiRd(STAT_OFF); while (rd[STAT_BUSY_BIT] !== 1'b0);
  endtask : runOp
  task automatic errCase(input logic [1:0] k, input logic [2:0] cls, input logic [7:0] msk,
      input logic [7:0] pv, input logic [7:0] srv, input logic [1:0] clr, input logic [7:0] sra);
    @(negedge mclk);
    flash.inject(k);
    runOp(FESC_OP_POLL);
    axiRd(STAT_OFF);
    check(32'(rd[6:4]), 32'(cls));
    check(32'(rd[2]), 32'h0);
    check(32'(rd[1]), 32'h1);
    axiRd(POLL_OFF);
    check(32'(rd[7:0] & msk), 32'(pv));
    check(32'(rd[6] ^ rd[22]), 32'h1);
    runOp(FESC_OP_SRREAD);
    axiRd(SWRD_OFF);
    check(32'(rd[7:0]), 32'(srv));
    runOp(clr);
    axiRd(CTRL_OFF);
    check(32'(rd[CTRL_CMD_LSB +: CTRL_CMD_W]), 32'(clr));
    runOp(FESC_OP_SRREAD);
    axiRd(STAT_OFF);
    check(32'(rd[6:4]), (k == 2'h2) ? 32'(FESC_CL_PROT) : 32'(FESC_CL_NONE));
    axiRd(SWRD_OFF);
    check(32'(rd[7:0]), 32'(sra));
    runOp(FESC_OP_POLL);
    axiRd(STAT_OFF);
    check(32'(rd[6:4]), 32'(FESC_CL_NONE));
    check(32'(rd[2]), 32'h1);
  endtask : errCase
  task automatic wrapUp();
    $display("comparisons %0d mismatches %0d", checksDone, failCount);
    if (failCount == 0 && checksDone > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : wrapUp
  // ----
  // Main sequence
  // ----
  initial begin
    reset <= 1'b1;
    s_axi_awaddr <= 8'h00;
    s_axi_araddr <= 8'h00;
    s_axi_wdata <= 32'h0;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    s_axi_bready <= 1'b0;
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b0;
    repeat (16) @(posedge mclk);
    reset <= 1'b0;
    axiRd(8'h10);
    check(32'(rsp), 32'h2);
    check(rd, 32'h00000000);
    axiWr(8'h14, 32'h0);
    check(32'(rsp), 32'h2);
    errCase(2'h1, FESC_CL_OPFAIL, 8'hAA, 8'h28, 8'hA0, FESC_OP_CLEAR, 8'h80);
    errCase(2'h1, FESC_CL_OPFAIL, 8'hAA, 8'h28, 8'hA0, FESC_OP_ABORTRST, 8'h80);
    errCase(2'h2, FESC_CL_BUSY, 8'hAA, 8'h08, 8'h00, FESC_OP_CLEAR, 8'hA2);
    errCase(2'h3, FESC_CL_ABORT, 8'hA2, 8'h82, 8'h98, FESC_OP_ABORTRST, 8'h80);
    errCase(2'h3, FESC_CL_ABORT, 8'hA2, 8'h82, 8'h98, FESC_OP_CLEAR, 8'h80);
    wrapUp();
  end
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      failCount++;
      wrapUp();
    end
  end
endmodule : fesc_host_tb_top
